// >>> core/sfc_pkg.sv
package sfc_pkg;

    // Register map
    localparam logic [7:0] SFC_ADDR_IF_EVT_CFG   = 8'h0d;
    localparam logic [7:0] SFC_ADDR_QUEUE_CFG    = 8'h0e;
    localparam logic [7:0] SFC_ADDR_IRQ_STATUS   = 8'h09;
    localparam logic [7:0] SFC_RST_IF_EVT_CFG    = 8'h00;
    localparam logic [7:0] SFC_RST_QUEUE_CFG     = 8'h00;

    // First feature register fields
    localparam int SFC_BIT_CAPTURE_FREEZE = 3;
    localparam int SFC_BIT_REARM_ON_CLEAR = 4;
    localparam int SFC_BIT_THREE_WIRE     = 5;
    localparam int SFC_BIT_TWO_WIRE_SEL   = 6;
    localparam int SFC_BIT_PERIPH_SEL     = 7;
    localparam logic [7:0] SFC_IF_EVT_WR_MASK = 8'hf8;

    // Second feature register fields
    localparam int SFC_BIT_BURST_WRAP     = 0;
    localparam int SFC_BIT_QUEUE_BURST    = 1;
    localparam int SFC_BIT_STATUS_TOKEN   = 2;
    localparam int SFC_BIT_QUEUE_TOKEN    = 3;
    localparam int SFC_BIT_WRITE_TO_CLEAR = 4;
    localparam int SFC_BIT_QUEUE_STREAM   = 5;
    localparam int SFC_BIT_TRIG_POLARITY  = 6;
    localparam int SFC_BIT_TRIG_ENABLE    = 7;

    // Burst address window
    localparam logic [7:0] SFC_BURST_FIRST     = 8'h02;
    localparam logic [7:0] SFC_BURST_LAST_DATA = 8'h07;
    localparam logic [7:0] SFC_BURST_LAST_STAT = 8'h09;

    localparam int SFC_AXIS_W = 16;

endpackage

// >>> core/sfc_burst_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sfc_burst_if;
    logic       start;
    logic [7:0] startAddr;
    logic       advance;
    logic       wrapSel;
    logic       queueBurst;
    logic [7:0] addr;
    logic       queuePop;

    modport ctrl (output start, output startAddr, output advance, output wrapSel, output queueBurst,
                  input addr, input queuePop);
    modport counter (input start, input startAddr, input advance, input wrapSel, input queueBurst,
                     output addr, output queuePop);
endinterface // sfc_burst_if

`default_nettype wire

// >>> core/sfc_burst_addr.sv
`timescale 1ns/1ps
`default_nettype none

module sfc_burst_addr
    import sfc_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Counter side
    sfc_burst_if.counter bus
);

    logic [7:0] addr_q;
    logic       popped_q;
    logic       pop_q;
    logic [7:0] wrapEnd;
    logic       popNow;

    // Same wrap point for every host interface [R15]
    assign wrapEnd = bus.wrapSel ? SFC_BURST_LAST_STAT : SFC_BURST_LAST_DATA; // [R13] [R14]
    // Only one sample per burst unless extended bursts are on [R16] [R17]
    assign popNow  = bus.advance && (addr_q == SFC_BURST_LAST_DATA) && (bus.queueBurst || !popped_q);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            addr_q <= SFC_BURST_FIRST;
        end
        else if (bus.start)
        begin
            addr_q <= bus.startAddr;
        end
        else if (bus.advance)
        begin
            addr_q <= (addr_q == wrapEnd) ? SFC_BURST_FIRST : addr_q + 8'h01; // [R13] [R14]
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst || bus.start)
        begin
            popped_q <= 1'b0;
        end
        else if (popNow)
        begin
            popped_q <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pop_q <= 1'b0;
        end
        else
        begin
            pop_q <= popNow && !bus.start;
        end
    end

    assign bus.addr     = addr_q;
    assign bus.queuePop = pop_q;

endmodule // sfc_burst_addr

`default_nettype wire

// >>> core/sfc_feature_config_regs.sv
// Notes on behaviour
// [R1] Host sets exactly one interface-select bit, for the bus it uses.
// [R2] With both select bits clear, axis result registers never update.
// [R3] Host writes zeros to the three low bits of the first register.
// [R4] Freeze bit set: queue stops capturing once the motion-watch interrupt is raised.
// [R5] Freeze is meant for use together with queue overwrite mode.
// [R6] After a motion-watch interrupt, the detector ignores events until cleared.
// [R7] Rearm bit set: clearing the interrupt also rearms the detector.
// [R8] Rearm bit clear: detector rearms only on leaving motion-watch mode.
// [R9] Three-wire bit picks three-wire peripheral mode on the data-out pin.
// [R10] Two-wire select set disables all peripheral-interface traffic.
// [R11] Peripheral select set disables all two-wire traffic.
// [R12] Select bits clear: keep the interface chosen at power-up.
// [R13] Wrap bit clear: burst address returns to 0x02 after 0x07.
// [R14] Wrap bit set: burst address returns to 0x02 after 0x09.
// [R15] Wrap and extended burst act the same on every host interface.
// [R16] Extended burst clear: one six-byte sample per burst transaction.
// [R17] Extended burst set: a burst may read many samples, up to whole queue.
// [R18] Write-to-clear in two-wire mode: reads keep flags, any write clears. Here reads still clear when two-wire comes from the strap alone.
// [R19] Overwrite mode and full queue: oldest sample dropped on new arrival.
// [R20] Host never sets both interface-select bits together.
`timescale 1ns/1ps
`default_nettype none

module sfc_feature_config_regs
    import sfc_pkg::*;
(
    // Clock, reset and power-up interface strap
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  strapPeriphMode,
    // Register port from the host interface logic
    input  wire logic                  regWrEn,
    input  wire logic                  regRdEn,
    input  wire logic [7:0]            regAddr,
    input  wire logic [7:0]            regWrData,
    output logic      [7:0]            regRdData,
    // Burst read control
    input  wire logic                  burstStart,
    input  wire logic                  burstAdvance,
    output logic      [7:0]            burstAddr,
    output logic                       queuePop,
    // Interface selection
    output logic                       twoWireActive,
    output logic                       periphActive,
    output logic                       threeWirePeriphMode,
    // Samples and queue
    input  wire logic                  sampleValid,
    input  wire logic [SFC_AXIS_W-1:0] sampleX,
    input  wire logic [SFC_AXIS_W-1:0] sampleY,
    input  wire logic [SFC_AXIS_W-1:0] sampleZ,
    input  wire logic                  queueFull,
    output logic [SFC_AXIS_W-1:0]      axisXResult,
    output logic [SFC_AXIS_W-1:0]      axisYResult,
    output logic [SFC_AXIS_W-1:0]      axisZResult,
    output logic                       queueCaptureEn,
    output logic                       queueDiscardOldest,
    output logic                       queueStreamMode,
    // Motion watch
    input  wire logic                  motionWatchMode,
    input  wire logic                  motionEvent,
    output logic                       motionWatchIrq,
    output logic                       detectorArmed,
    output logic                       irqClearPulse,
    // Remaining second-register controls
    output logic                       externalTriggerEnable,
    output logic                       externalTriggerPolarity,
    output logic                       statusTokenEnable,
    output logic                       queueTokenEnable
);

    logic [7:0]            ifEvtCfg_q;
    logic [7:0]            queueCfg_q;
    logic                  strapPeriph_q;
    logic                  strapTaken_q;
    logic [7:0]            rdData_q;
    logic                  irq_q;
    logic                  armed_q;
    logic                  modePrev_q;
    logic [SFC_AXIS_W-1:0] axisX_q;
    logic [SFC_AXIS_W-1:0] axisY_q;
    logic [SFC_AXIS_W-1:0] axisZ_q;
    logic                  twoWireSel;
    logic                  periphSel;
    logic                  wrIfEvt;
    logic                  wrQueue;
    logic                  statusWr;
    logic                  statusRd;
    logic                  clearIrq;
    logic                  irqSet;
    logic                  resultsEn;

    sfc_burst_if burstBus ();

    assign twoWireSel = ifEvtCfg_q[SFC_BIT_TWO_WIRE_SEL];
    assign periphSel  = ifEvtCfg_q[SFC_BIT_PERIPH_SEL];
    assign wrIfEvt    = regWrEn && (regAddr == SFC_ADDR_IF_EVT_CFG);
    assign wrQueue    = regWrEn && (regAddr == SFC_ADDR_QUEUE_CFG);

    // Configuration registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ifEvtCfg_q <= SFC_RST_IF_EVT_CFG;
        end
        else if (wrIfEvt)
        begin
            // Low bits are held at zero whatever the host writes [R3]
            ifEvtCfg_q <= regWrData & SFC_IF_EVT_WR_MASK;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            queueCfg_q <= SFC_RST_QUEUE_CFG;
        end
        else if (wrQueue)
        begin
            queueCfg_q <= regWrData;
        end
    end

    // Power-up interface strap, caught on the first clock after reset
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            strapTaken_q  <= 1'b0;
            strapPeriph_q <= 1'b0;
        end
        else if (!strapTaken_q)
        begin
            strapTaken_q  <= 1'b1;
            strapPeriph_q <= strapPeriphMode;
        end
    end

    // Both selects set is undefined; both ports then go quiet [R20]
    assign twoWireActive       = !periphSel && (twoWireSel || !strapPeriph_q); // [R11] [R12]
    assign periphActive        = !twoWireSel && (periphSel || strapPeriph_q);  // [R10] [R12]
    assign threeWirePeriphMode = ifEvtCfg_q[SFC_BIT_THREE_WIRE];               // [R9]

    // Register read data
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rdData_q <= 8'h00;
        end
        else if (regRdEn)
        begin
            case (regAddr)
                SFC_ADDR_IF_EVT_CFG: rdData_q <= ifEvtCfg_q;
                SFC_ADDR_QUEUE_CFG:  rdData_q <= queueCfg_q;
                default:             rdData_q <= 8'h00;
            endcase
        end
    end

    assign regRdData = rdData_q;

    // Interrupt clear: read-to-clear only on two-wire, and not when write-to-clear is set with two-wire selected in the register
    assign statusWr = regWrEn && (regAddr == SFC_ADDR_IRQ_STATUS);
    assign statusRd = regRdEn && (regAddr == SFC_ADDR_IRQ_STATUS);
    // Write-to-clear only counts once two-wire is selected in the register, not by strap alone
    assign clearIrq = statusWr
                   || (statusRd && twoWireActive && !(queueCfg_q[SFC_BIT_WRITE_TO_CLEAR] && twoWireSel)); // [R18]
    assign irqClearPulse = clearIrq;

    // Motion watch interrupt and detector arming
    assign irqSet = motionWatchMode && motionEvent && armed_q; // [R6]

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            irq_q <= 1'b0;
        end
        else if (irqSet)
        begin
            // A new event wins over a clear in the same cycle
            irq_q <= 1'b1;
        end
        else if (clearIrq)
        begin
            irq_q <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            modePrev_q <= 1'b0;
        end
        else
        begin
            modePrev_q <= motionWatchMode;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            armed_q <= 1'b1;
        end
        else if (irqSet)
        begin
            armed_q <= 1'b0; // [R6]
        end
        else if (modePrev_q && !motionWatchMode)
        begin
            armed_q <= 1'b1; // [R8]
        end
        else if (clearIrq && irq_q && ifEvtCfg_q[SFC_BIT_REARM_ON_CLEAR])
        begin
            armed_q <= 1'b1; // [R7]
        end
    end

    assign motionWatchIrq = irq_q;
    assign detectorArmed  = armed_q;

    // Queue capture control
    assign queueStreamMode    = queueCfg_q[SFC_BIT_QUEUE_STREAM];
    // Freeze only makes sense alongside overwrite mode [R5]
    assign queueCaptureEn     = !(ifEvtCfg_q[SFC_BIT_CAPTURE_FREEZE] && irq_q);            // [R4]
    assign queueDiscardOldest = queueStreamMode && queueFull && sampleValid && queueCaptureEn; // [R19]

    // Axis results, frozen until an interface is selected
    assign resultsEn = twoWireSel || periphSel; // [R1] [R2]

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            axisX_q <= '0;
            axisY_q <= '0;
            axisZ_q <= '0;
        end
        else if (sampleValid && resultsEn)
        begin
            axisX_q <= sampleX; // [R2]
            axisY_q <= sampleY;
            axisZ_q <= sampleZ;
        end
    end

    assign axisXResult = axisX_q;
    assign axisYResult = axisY_q;
    assign axisZResult = axisZ_q;

    // Burst address counter, independent of the host interface in use
    assign burstBus.start      = burstStart;
    assign burstBus.startAddr  = regAddr;
    assign burstBus.advance    = burstAdvance;
    assign burstBus.wrapSel    = queueCfg_q[SFC_BIT_BURST_WRAP];  // [R13] [R14] [R15]
    assign burstBus.queueBurst = queueCfg_q[SFC_BIT_QUEUE_BURST]; // [R16] [R17]

    sfc_burst_addr burstCounter (
        .clk  (clk),
        .srst (srst),
        .bus  (burstBus.counter)
    );

    assign burstAddr = burstBus.addr;
    assign queuePop  = burstBus.queuePop;

    // Controls passed to neighbouring logic
    assign externalTriggerEnable   = queueCfg_q[SFC_BIT_TRIG_ENABLE];
    assign externalTriggerPolarity = queueCfg_q[SFC_BIT_TRIG_POLARITY];
    assign statusTokenEnable       = queueCfg_q[SFC_BIT_STATUS_TOKEN];
    assign queueTokenEnable        = queueCfg_q[SFC_BIT_QUEUE_TOKEN];

endmodule // sfc_feature_config_regs

`default_nettype wire

// >>> verification/sfc_feature_config_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sfc_feature_config_regs_assertions
    import sfc_pkg::*;
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  srst,
    // Register and burst ports
    input wire logic                  regWrEn,
    input wire logic                  regRdEn,
    input wire logic [7:0]            regAddr,
    input wire logic [7:0]            regWrData,
    input wire logic                  burstStart,
    input wire logic                  burstAdvance,
    input wire logic [7:0]            burstAddr,
    // Interface, samples, motion
    input wire logic                  twoWireActive,
    input wire logic                  periphActive,
    input wire logic                  sampleValid,
    input wire logic [SFC_AXIS_W-1:0] sampleX,
    input wire logic [SFC_AXIS_W-1:0] axisXResult,
    input wire logic                  queueCaptureEn,
    input wire logic                  motionWatchMode,
    input wire logic                  motionWatchIrq,
    input wire logic                  detectorArmed,
    input wire logic                  irqClearPulse
);
    // Shadow copies, since the checker cannot see the register bodies
    logic [7:0] cfgQ;
    logic [7:0] qcfgQ;
    logic [7:0] nextAddr;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cfgQ  <= 8'h00;
            qcfgQ <= 8'h00;
        end
        else if (regWrEn && regAddr == SFC_ADDR_IF_EVT_CFG)
            cfgQ <= regWrData & SFC_IF_EVT_WR_MASK;
        else if (regWrEn && regAddr == SFC_ADDR_QUEUE_CFG)
            qcfgQ <= regWrData;
    end
    assign nextAddr = (burstAddr == (qcfgQ[SFC_BIT_BURST_WRAP] ? SFC_BURST_LAST_STAT : SFC_BURST_LAST_DATA))
                    ? SFC_BURST_FIRST : burstAddr + 8'h01;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence irqPending;
        motionWatchIrq && !irqClearPulse;
    endsequence
    sequence stepIn;
        burstAdvance && !burstStart;
    endsequence
    AST_NO_SAMPLE: assert property (sampleValid && cfgQ[7:6] == 2'b00 |=> $stable(axisXResult))
        else $error("axis moved");
    AST_SAMPLE: assert property (sampleValid && cfgQ[7:6] != 2'b00 |=> axisXResult == $past(sampleX))
        else $error("axis not stored");
    AST_TWO_OFF: assert property (cfgQ[7:6] == 2'b10 |-> !twoWireActive && periphActive)
        else $error("two-wire on");
    AST_PERIPH_OFF: assert property (cfgQ[7:6] == 2'b01 |-> !periphActive && twoWireActive)
        else $error("periph on");
    AST_FREEZE: assert property (queueCaptureEn == !(motionWatchIrq && cfgQ[3]))
        else $error("capture wrong");
    AST_IRQ_HOLD: assert property (irqPending |=> motionWatchIrq)
        else $error("irq lost");
    AST_REARM: assert property (motionWatchIrq && irqClearPulse && cfgQ[4] |=> detectorArmed && !motionWatchIrq)
        else $error("no rearm");
    AST_NO_REARM: assert property (!detectorArmed && !cfgQ[4] && motionWatchMode
        && $past(motionWatchMode) |=> !detectorArmed)
        else $error("early rearm");
    AST_WRAP: assert property (stepIn |=> burstAddr == $past(nextAddr))
        else $error("burst step");
    AST_WR_CLEAR: assert property (regWrEn && regAddr == SFC_ADDR_IRQ_STATUS |-> irqClearPulse)
        else $error("no clear");
endmodule // sfc_feature_config_regs_assertions
bind sfc_feature_config_regs sfc_feature_config_regs_assertions chk (.clk, .srst, .regWrEn, .regRdEn,
    .regAddr, .regWrData, .burstStart, .burstAdvance, .burstAddr, .twoWireActive, .periphActive, .sampleValid,
    .sampleX, .axisXResult, .queueCaptureEn, .motionWatchMode, .motionWatchIrq, .detectorArmed, .irqClearPulse);
`default_nettype wire

// >>> verification/sfc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model
(
    // Clock
    input  wire logic       clk,
    // Register and burst port
    output logic            regWrEn,
    output logic            regRdEn,
    output logic [7:0]      regAddr,
    output logic [7:0]      regWrData,
    output logic            burstStart,
    output logic            burstAdvance,
    input  wire logic [7:0] regRdData
);
    initial
    begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        burstStart = 1'b0;
        burstAdvance = 1'b0;
    end
    // Callers set one select bit only
    task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clk) #1;
        regWrEn = 1'b0;
    endtask
    task automatic readReg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge clk) #1;
        regRdEn = 1'b0;
        d = regRdData;
    endtask
    task automatic burst(input logic [7:0] a);
        @(posedge clk) #1;
        regAddr = a;
        burstStart = 1'b1;
        @(posedge clk) #1;
        burstStart = 1'b0;
    endtask
    task automatic advance;
        @(posedge clk) #1;
        burstAdvance = 1'b1;
        @(posedge clk) #1;
        burstAdvance = 1'b0;
    endtask
endmodule // sfc_host_model
`default_nettype wire

// >>> verification/sfc_feature_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sfc_feature_config_regs_tb import sfc_pkg::*;;
    logic        clk, srst, strapPeriphMode, regWrEn, regRdEn, burstStart, burstAdvance, queuePop;
    logic        twoWireActive, periphActive, threeWirePeriphMode, sampleValid, queueFull;
    logic        motionWatchMode, motionEvent, motionWatchIrq, detectorArmed, queueCaptureEn;
    logic [7:0]  regAddr, regWrData, regRdData, burstAddr;
    logic [15:0] sampleX, axisXResult, axisYResult, axisZResult;
    logic        queueDiscardOldest, queueStreamMode, externalTriggerEnable, externalTriggerPolarity;
    logic        statusTokenEnable, queueTokenEnable;
    int          badCount, checksDone;
    sfc_host_model host (.clk, .regWrEn, .regRdEn, .regAddr, .regWrData, .burstStart, .burstAdvance, .regRdData);
    sfc_feature_config_regs DUT (.clk, .srst, .strapPeriphMode, .regWrEn, .regRdEn, .regAddr, .regWrData,
        .regRdData, .burstStart, .burstAdvance, .burstAddr, .queuePop, .twoWireActive, .periphActive,
        .threeWirePeriphMode, .sampleValid, .sampleX, .sampleY(sampleX), .sampleZ(sampleX), .queueFull,
        .axisXResult, .axisYResult, .axisZResult, .queueCaptureEn, .queueDiscardOldest,
        .queueStreamMode, .motionWatchMode, .motionEvent, .motionWatchIrq, .detectorArmed,
        .irqClearPulse(), .externalTriggerEnable, .externalTriggerPolarity, .statusTokenEnable,
        .queueTokenEnable);
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            badCount++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stopTest;
        if (badCount == 0 && checksDone > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic sample(input logic [15:0] v);
        @(posedge clk) #1;
        sampleX = v;
        sampleValid = 1'b1;
        @(posedge clk) #1;
        sampleValid = 1'b0;
    endtask
    task automatic evt;
        @(posedge clk) #1;
        motionEvent = 1'b1;
        @(posedge clk) #1;
        motionEvent = 1'b0;
    endtask
    initial
    begin
        #20000;
        badCount++;
        stopTest();
    end
    initial
    begin
        logic [7:0] d;
        logic [7:0] e;
        logic       first;
        srst = 1'b1;
        strapPeriphMode = 1'b1;
        sampleValid = 1'b0;
        sampleX = 16'h0000;
        queueFull = 1'b0;
        motionWatchMode = 1'b0;
        motionEvent = 1'b0;
        repeat (10) @(posedge clk);
        #1 srst = 1'b0;
        host.readReg(SFC_ADDR_IF_EVT_CFG, d);
        chk(d, 8'h00);
        host.readReg(SFC_ADDR_QUEUE_CFG, d);
        chk(d, 8'h00);
        host.readReg(8'h20, d);
        chk(d, 8'h00);
        chk({twoWireActive, periphActive}, 2'b01);
        sample(16'h1234);
        chk(axisXResult, 16'h0000);
        host.writeReg(SFC_ADDR_IF_EVT_CFG, 8'ha0);
        host.readReg(SFC_ADDR_IF_EVT_CFG, d);
        chk(d, 8'ha0);
        chk({twoWireActive, periphActive, threeWirePeriphMode}, 3'b011);
        sample(16'h1234);
        chk(axisXResult, 16'h1234);
        host.writeReg(SFC_ADDR_QUEUE_CFG, 8'h20);
        host.writeReg(SFC_ADDR_IF_EVT_CFG, 8'h58);
        chk({twoWireActive, periphActive, threeWirePeriphMode}, 3'b100);
        @(posedge clk) #1 motionWatchMode = 1'b1;
        evt();
        chk({motionWatchIrq, detectorArmed, queueCaptureEn}, 3'b100);
        evt();
        chk({motionWatchIrq, detectorArmed}, 2'b10);
        host.writeReg(SFC_ADDR_QUEUE_CFG, 8'h30);
        host.readReg(SFC_ADDR_IRQ_STATUS, d);
        chk(motionWatchIrq, 1'b1);
        host.writeReg(SFC_ADDR_IRQ_STATUS, 8'h00);
        chk({motionWatchIrq, detectorArmed, queueCaptureEn}, 3'b011);
        host.writeReg(SFC_ADDR_IF_EVT_CFG, 8'h40);
        evt();
        host.writeReg(SFC_ADDR_IRQ_STATUS, 8'h00);
        chk({motionWatchIrq, detectorArmed}, 2'b00);
        host.writeReg(SFC_ADDR_QUEUE_CFG, 8'h00);
        @(posedge clk) #1 motionWatchMode = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(detectorArmed, 1'b1);
        motionWatchMode = 1'b1;
        evt();
        host.readReg(SFC_ADDR_IRQ_STATUS, d);
        chk(motionWatchIrq, 1'b0);
        host.writeReg(SFC_ADDR_QUEUE_CFG, 8'hec);
        chk({externalTriggerEnable, externalTriggerPolarity, queueStreamMode, queueTokenEnable, statusTokenEnable},
            5'h1f);
        @(posedge clk) #1;
        sampleX = 16'h5a5a;
        sampleValid = 1'b1;
        #1 chk(queueDiscardOldest, 1'b0);
        @(posedge clk) #1;
        queueFull = 1'b1;
        #1 chk(queueDiscardOldest, 1'b1);
        @(posedge clk) #1;
        sampleValid = 1'b0;
        queueFull = 1'b0;
        chk(axisYResult, 16'h5a5a);
        chk(axisZResult, 16'h5a5a);
        for (int c = 0; c < 4; c++)
        begin
            host.writeReg(SFC_ADDR_QUEUE_CFG, 8'(c));
            host.burst(8'h02);
            e = 8'h02;
            first = 1'b1;
            repeat (14)
            begin
                host.advance();
                chk(queuePop, e == 8'h07 && (first || c[1]));
                if (e == 8'h07)
                    first = 1'b0;
                e = (e == (c[0] ? 8'h09 : 8'h07)) ? 8'h02 : e + 8'h01;
                chk(burstAddr, e);
            end
        end
        stopTest();
    end
endmodule // sfc_feature_config_regs_tb
`default_nettype wire
